// ===== hw/sync_serial_pkg.sv
/*
 * constants, register map and types for the synchronous serial port in spi mode.
 * assumes a 32-bit classic wishbone bus; registers sit in the low byte of each word.
 */
package sync_serial_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_STATUS   = 5'h00;
    localparam logic [4:0] OFS_CONTROL1 = 5'h04;
    localparam logic [4:0] OFS_CONTROL3 = 5'h08;
    localparam logic [4:0] OFS_DATA     = 5'h0c;
    localparam logic [4:0] OFS_BAUD     = 5'h10;
    localparam logic [4:0] OFS_FLAGS    = 5'h14;

    // port_status_reg fields
    localparam int ST_SMP = 7;
    localparam int ST_CKE = 6;
    localparam int ST_BF  = 0;
    // port_control_one fields
    localparam int C1_WRITE_COLLISION_FLAG = 7;
    localparam int C1_OV   = 6;
    localparam int C1_EN   = 5;
    localparam int C1_CKP  = 4;
    localparam int C1_MODE = 0;
    // port_control_three fields
    localparam int C3_BUFFER_OVERWRITE_ENABLE = 4;
    // flag register fields, and the SEL_I bit for the low byte
    localparam int FL_DONE    = 0;
    localparam int FL_WAKE_EN = 1;
    localparam int SEL_LOW    = 0;

    // port_mode_field encodings
    localparam logic [3:0] MODE_DIV4   = 4'h0;
    localparam logic [3:0] MODE_DIV16  = 4'h1;
    localparam logic [3:0] MODE_DIV64  = 4'h2;
    localparam logic [3:0] MODE_TIMER  = 4'h3;
    localparam logic [3:0] MODE_SLV_SS = 4'h4;
    localparam logic [3:0] MODE_SLV    = 4'h5;
    localparam logic [3:0] MODE_RELOAD = 4'ha;

    // half bit periods in clock cycles
    localparam logic [9:0] HALF_DIV4  = 10'h002;
    localparam logic [9:0] HALF_DIV16 = 10'h008;
    localparam logic [9:0] HALF_DIV64 = 10'h020;
    localparam logic [9:0] CNT_ONE    = 10'h001;

    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_ONE  = 3'h1;
    localparam logic [2:0] BIT_ZERO = 3'h0;

    typedef enum logic [1:0] {XFER_IDLE, XFER_LEAD, XFER_TRAIL} xfer_e;
endpackage

// ===== hw/bit_rate_gen.sv
/*
 * master bit rate generator: one pulse per half bit period.
 * assumes mode and reload stay steady while a byte is clocked.
 */
`timescale 1ns/1ns
`default_nettype none
module bit_rate_gen
    import sync_serial_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [3:0] mode,
    input  wire logic [7:0] reload,
    input  wire logic       t2_tick,
    output logic            half_tick
);
    typedef struct packed {
        logic [9:0] cnt;
        logic       tick;
    } brg_s;

    brg_s brg_r;
    brg_s brg_nxt;

    // half period in clocks for the divider modes
    function automatic logic [9:0] half_limit(input logic [3:0] m, input logic [7:0] rl);
        logic [9:0] v;
        v = HALF_DIV4;
        case (m)
            MODE_DIV16:  v = HALF_DIV16;
            MODE_DIV64:  v = HALF_DIV64;
            MODE_RELOAD: v = 10'({2'h0, rl} + CNT_ONE) << 1;
            default:     v = HALF_DIV4;
        endcase
        return v;
    endfunction

    always_comb begin
        brg_nxt      = brg_r;
        brg_nxt.tick = 1'b0;
        if (!run) begin
            brg_nxt.cnt = '0;
        end else if (mode == MODE_TIMER) begin
            brg_nxt.tick = t2_tick; // RULE_12
        end else if (brg_r.cnt >= half_limit(mode, reload) - CNT_ONE) begin
            brg_nxt.cnt  = '0;
            brg_nxt.tick = 1'b1; // RULE_12
        end else begin
            brg_nxt.cnt = brg_r.cnt + CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            brg_r <= '0;
        end else begin
            brg_r <= brg_nxt;
        end
    end

    assign half_tick = brg_r.tick;
endmodule // bit_rate_gen
`default_nettype wire

// ===== hw/sync_serial_port.sv
/*
 * synchronous serial port, spi mode, master and slave, with wishbone register access.
 * assumes pins are sampled on MCLK; SCK, SDI and SS_N are asynchronous to it.
 */
// The implementer's own choices: the address map and the Wishbone interface to the registers.
// Contract
// RULE_01: after eight bits, byte goes to buffer; set buffer full and done flags.
// RULE_02: writing the data buffer loads buffer and shift register together.
// RULE_03: bytes move msb first; new bits enter at the lsb.
// RULE_04: a buffer write during a transfer is dropped and sets write collision.
// RULE_05: while write collision stays set, buffer writes do not complete.
// RULE_06: reading the data buffer clears buffer full.
// RULE_07: the port works only while enabled; reconfigure with it cleared.
// RULE_08: software sets pin directions; sck out as master, in as slave. The port drives SCK_OE and SDO_OE itself from enable, mode and, in mode 0100, SS_N.
// RULE_09: config in control one low six bits and status top two bits.
// RULE_10: master starts clocking as soon as the buffer is written.
// RULE_11: master keeps sampling sdi when sdo is unused, normal flags.
// RULE_12: master rate is osc/4, /16, /64, timer two /2 or reload divider.
// RULE_13: clock idle polarity sets sck idle level and waveform.
// RULE_14: with clock edge select set, sdo is valid before first sck edge.
// RULE_15: sample phase picks middle or end of data output time.
// RULE_16: slave shifts on external sck and flags done on the last bit.
// RULE_17: software checks sck idles at the selected level before slave enable.
// RULE_18: slave keeps shifting in sleep; a completed byte requests wake.
// RULE_19: buffer overwrite enable lets writes in while a byte is unread.
// RULE_20: data leaves on one sck edge and is captured on the other.
// RULE_21: mode 0100 is slave with select; active and sdo driven when low.
// RULE_22: select high or disable releases sdo and zeroes the bit counter.
// RULE_23: a three-bit counter; the eighth counted edge completes the byte.
`timescale 1ns/1ns
`default_nettype none
module sync_serial_port
    import sync_serial_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [4:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        SCK_I,
    output logic             SCK_O,
    output logic             SCK_OE,
    input  wire logic        SDI,
    output logic             SDO_O,
    output logic             SDO_OE,
    input  wire logic        SS_N,
    input  wire logic        TIMER_TWO_TICK,
    input  wire logic        SLEEP,
    output logic             XFER_DONE,
    output logic             WAKE_REQ
);
    localparam int PIN_SCK = 2;
    localparam int PIN_SDI = 1;
    localparam int PIN_SS  = 0;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic        input_sample_phase;
        logic        cke;
        logic        bf;
        logic        write_collision_flag;
        logic        ov;
        logic        en;
        logic        clock_idle_polarity;
        logic [3:0]  mode;
        logic        buffer_overwrite_enable;
        logic [7:0]  baud;
        logic        done;
        logic        wake_en;
        logic [7:0]  dbuf;
        logic [7:0]  shreg;
        logic        samp;
        logic [2:0]  cnt;
        xfer_e       state;
        logic        sck;
        logic        sck_oe;
        logic        sdo;
        logic        sdo_oe;
        logic        wake;
        logic [2:0]  meta;
        logic [2:0]  sync;
        logic        sck_prev;
    } port_s;

    port_s st_r;
    port_s st_nxt;

    logic       half_tick;
    logic       is_slave;
    logic       busy;
    logic       wb_req;
    logic       wr_data;
    logic       rd_data;
    logic       wr_ok;
    logic       cpl;
    logic [7:0] rx_byte;

    function automatic logic [31:0] read_word(input port_s s, input logic [4:0] a);
        logic [31:0] w;
        w = '0;
        case (a)
            OFS_STATUS:   w[7:0] = {s.input_sample_phase, s.cke, 5'h00, s.bf};
            OFS_CONTROL1: w[7:0] = {s.write_collision_flag, s.ov, s.en, s.clock_idle_polarity, s.mode};
            OFS_CONTROL3: w[C3_BUFFER_OVERWRITE_ENABLE] = s.buffer_overwrite_enable;
            OFS_DATA:     w[7:0] = s.dbuf;
            OFS_BAUD:     w[7:0] = s.baud;
            OFS_FLAGS:    w[1:0] = {s.wake_en, s.done};
            default:      w = '0;
        endcase
        return w;
    endfunction

    bit_rate_gen u_rate (
        .clk       (MCLK),
        .rst       (SYS_RST),
        .run       (st_r.en && !is_slave && st_r.state != XFER_IDLE && !SLEEP),
        .mode      (st_r.mode),
        .reload    (st_r.baud),
        .t2_tick   (TIMER_TWO_TICK),
        .half_tick (half_tick)
    );

    always_comb begin
        logic lead;
        logic trail;
        logic ss_ok;
        logic bit_in;
        lead    = 1'b0;
        trail   = 1'b0;
        ss_ok   = 1'b0;
        bit_in  = 1'b0;
        cpl     = 1'b0;
        rx_byte = '0;
        st_nxt  = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.meta = {SCK_I, SDI, SS_N};
        st_nxt.sync = st_r.meta;
        st_nxt.sck_prev = st_r.sync[PIN_SCK];
        is_slave = (st_r.mode == MODE_SLV_SS) || (st_r.mode == MODE_SLV);
        busy     = (st_r.state != XFER_IDLE) || (st_r.cnt != BIT_ZERO);
        wb_req   = CYC_I && STB_I && !st_r.ack;
        wr_data  = wb_req && WE_I && SEL_I[SEL_LOW] && ADR_I == OFS_DATA;
        rd_data  = wb_req && !WE_I && ADR_I == OFS_DATA;
        wr_ok    = wr_data && st_r.en && !st_r.write_collision_flag && !busy // RULE_04 RULE_05
                   && !(is_slave && st_r.bf && !st_r.buffer_overwrite_enable); // RULE_19

        // register bus
        if (wb_req) begin
            st_nxt.ack = 1'b1;
            st_nxt.dat = WE_I ? 32'h0000_0000 : read_word(st_r, ADR_I);
        end
        if (rd_data) begin
            st_nxt.bf = 1'b0; // RULE_06
        end
        if (wb_req && WE_I && SEL_I[SEL_LOW]) begin
            case (ADR_I)
                OFS_STATUS: begin
                    st_nxt.input_sample_phase = DAT_I[ST_SMP]; // RULE_09
                    st_nxt.cke = DAT_I[ST_CKE];
                end
                OFS_CONTROL1: begin
                    st_nxt.write_collision_flag = st_r.write_collision_flag && DAT_I[C1_WRITE_COLLISION_FLAG]; // RULE_05
                    st_nxt.ov   = st_r.ov && DAT_I[C1_OV];
                    st_nxt.en   = DAT_I[C1_EN]; // RULE_07
                    st_nxt.clock_idle_polarity  = DAT_I[C1_CKP]; // RULE_09
                    st_nxt.mode = DAT_I[C1_MODE +: 4];
                end
                OFS_CONTROL3: st_nxt.buffer_overwrite_enable = DAT_I[C3_BUFFER_OVERWRITE_ENABLE];
                OFS_BAUD:     st_nxt.baud = DAT_I[7:0];
                OFS_FLAGS: begin
                    st_nxt.done    = st_r.done && !DAT_I[FL_DONE];
                    st_nxt.wake_en = DAT_I[FL_WAKE_EN];
                end
                default: st_nxt.wake_en = st_r.wake_en;
            endcase
        end
        if (wr_ok) begin
            st_nxt.dbuf  = DAT_I[7:0]; // RULE_02
            st_nxt.shreg = DAT_I[7:0];
            st_nxt.sdo   = DAT_I[7]; // RULE_14
            st_nxt.cnt   = BIT_ZERO;
            if (!is_slave) begin
                st_nxt.state = XFER_LEAD; // RULE_10
                st_nxt.sck   = st_r.cke ? st_r.clock_idle_polarity : !st_r.clock_idle_polarity; // RULE_13
            end
        end else if (wr_data) begin
            st_nxt.write_collision_flag = 1'b1; // RULE_04
        end

        // shift engine
        if (!st_r.en) begin
            st_nxt.cnt    = BIT_ZERO; // RULE_07 RULE_22
            st_nxt.state  = XFER_IDLE;
            st_nxt.sdo_oe = 1'b0;
            st_nxt.sck_oe = 1'b0;
            st_nxt.sck    = st_r.clock_idle_polarity;
        end else if (!is_slave) begin
            st_nxt.sck_oe = 1'b1;
            st_nxt.sdo_oe = 1'b1; // RULE_11
            case (st_r.state)
                XFER_IDLE: begin
                    if (!wr_ok) begin
                        st_nxt.sck = st_r.clock_idle_polarity; // RULE_13
                    end
                end
                XFER_LEAD: begin
                    if (half_tick) begin
                        st_nxt.sck = !st_r.sck; // RULE_20
                        if (!st_r.input_sample_phase) begin
                            st_nxt.samp = st_r.sync[PIN_SDI]; // RULE_15
                        end
                        st_nxt.state = XFER_TRAIL;
                    end
                end
                XFER_TRAIL: begin
                    if (half_tick) begin
                        bit_in = st_r.input_sample_phase ? st_r.sync[PIN_SDI] : st_r.samp; // RULE_15
                        st_nxt.shreg = {st_r.shreg[6:0], bit_in}; // RULE_03
                        st_nxt.sdo   = st_nxt.shreg[7]; // RULE_20
                        st_nxt.cnt   = st_r.cnt + BIT_ONE; // RULE_23
                        st_nxt.sck   = !st_r.sck;
                        st_nxt.state = XFER_LEAD;
                        if (st_r.cnt == BIT_LAST) begin
                            cpl          = 1'b1; // RULE_11 RULE_23
                            rx_byte      = st_nxt.shreg;
                            st_nxt.sck   = st_r.clock_idle_polarity;
                            st_nxt.state = XFER_IDLE;
                        end
                    end
                end
                default: st_nxt.state = XFER_IDLE;
            endcase
        end else begin
            st_nxt.sck_oe = 1'b0;
            st_nxt.state  = XFER_IDLE;
            ss_ok = (st_r.mode != MODE_SLV_SS) || !st_r.sync[PIN_SS]; // RULE_21
            lead  = (st_r.sync[PIN_SCK] != st_r.sck_prev) && (st_r.sync[PIN_SCK] != st_r.clock_idle_polarity);
            trail = (st_r.sync[PIN_SCK] != st_r.sck_prev) && (st_r.sync[PIN_SCK] == st_r.clock_idle_polarity);
            if (!ss_ok) begin
                st_nxt.cnt    = BIT_ZERO; // RULE_22
                st_nxt.sdo_oe = 1'b0;
            end else begin
                st_nxt.sdo_oe = 1'b1; // RULE_21
                if (st_r.cke ? lead : trail) begin
                    st_nxt.shreg = {st_r.shreg[6:0], st_r.sync[PIN_SDI]}; // RULE_03 RULE_16
                    st_nxt.cnt   = st_r.cnt + BIT_ONE; // RULE_23
                    if (st_r.cnt == BIT_LAST) begin
                        cpl     = 1'b1; // RULE_16 RULE_18
                        rx_byte = st_nxt.shreg;
                    end
                end else if (st_r.cke ? trail : lead) begin
                    st_nxt.sdo = st_r.shreg[7]; // RULE_20
                end
            end
        end

        // byte completion wins over a same-cycle read or clear
        if (cpl) begin
            st_nxt.done = 1'b1; // RULE_01
            if (is_slave && st_r.bf && !st_r.buffer_overwrite_enable) begin
                st_nxt.ov = 1'b1; // RULE_19
            end else begin
                st_nxt.dbuf = rx_byte; // RULE_01
                st_nxt.bf   = 1'b1;
            end
        end
        st_nxt.wake = SLEEP && st_r.wake_en && st_nxt.done; // RULE_18
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            st_r       <= '0;
            st_r.state <= XFER_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign DAT_O     = st_r.dat;
    assign ACK_O     = st_r.ack;
    assign SCK_O     = st_r.sck;
    assign SCK_OE    = st_r.sck_oe;
    assign SDO_O     = st_r.sdo;
    assign SDO_OE    = st_r.sdo_oe;
    assign XFER_DONE = st_r.done;
    assign WAKE_REQ  = st_r.wake;

    default clocking dc @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    chk_done_sets_flags: assert property (cpl |=> st_r.done && (st_r.bf || st_r.ov)) // RULE_01
        else $error("byte completion did not set done and full");
    chk_write_loads_buf: assert property (wr_ok |=> st_r.dbuf == $past(DAT_I[7:0])
        && st_r.shreg == $past(DAT_I[7:0])) // RULE_02
        else $error("accepted write did not load buffer and shift register");
    chk_busy_write_write_collision_flag: assert property (wr_data && busy && st_r.en |=> st_r.write_collision_flag) // RULE_04
        else $error("write during transfer did not flag collision");
    chk_write_collision_flag_blocks_write: assert property (wr_data && st_r.write_collision_flag && !busy |=> $stable(st_r.dbuf)) // RULE_05
        else $error("write went through while collision flag set");
    chk_read_clears_bf: assert property (rd_data && !cpl |=> !st_r.bf) // RULE_06
        else $error("buffer read did not clear full flag");
    chk_disable_releases: assert property (!st_r.en |=> !SDO_OE && !SCK_OE
        && st_r.cnt == BIT_ZERO) // RULE_07
        else $error("disabled port still drives pins");
    chk_master_start: assert property (wr_ok && !is_slave |=> st_r.state == XFER_LEAD
        ##0 SCK_OE) // RULE_10
        else $error("master write did not start clocking");
    chk_select_release: assert property (st_r.en && st_r.mode == MODE_SLV_SS
        && st_r.sync[PIN_SS] |=> !SDO_OE && st_r.cnt == BIT_ZERO) // RULE_22
        else $error("select high did not release sdo");
    chk_eighth_edge: assert property (cpl |-> st_r.cnt == BIT_LAST) // RULE_23
        else $error("byte completed on wrong bit count");
    chk_idle_level: assert property ((st_r.en && !is_slave && st_r.state == XFER_IDLE
        && !wr_ok && $stable(st_r.clock_idle_polarity)) [*2] |-> SCK_O == st_r.clock_idle_polarity) // RULE_13
        else $error("sck not at idle level");
endmodule // sync_serial_port
`default_nettype wire

// ===== tb/spi_far_end.sv
/*
 * far side of the spi link: a slave while the port is master, a master otherwise.
 * assumes the bench sets lead for the role and pol to the port's clock idle level.
 */
`timescale 1ns/1ns
`default_nettype none
module spi_far_end (
    input  wire logic lead,
    input  wire logic pol,
    input  wire logic sck_in,
    input  wire logic sdo_in,
    output logic      sck_out,
    output logic      sdi_out,
    output logic      ss_n
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    int         n  = 0;
    initial begin
        sck_out = 1'b0;
        sdi_out = 1'b0;
        ss_n    = 1'b1;
    end
    // slave role: capture leaving idle, shift on the return to idle
    always @(sck_in) begin
        if (!lead && sck_in !== pol) begin
            rx = {rx[6:0], sdo_in};
            n  = n + 1;
        end else if (!lead && n > 0) begin
            tx      = {tx[6:0], ~tx[0]};
            sdi_out = (n >= 8) ? ~sdi_out : tx[7];
        end
    end
    task automatic load(input logic [7:0] b);
        tx      = b;
        rx      = 8'h00;
        n       = 0;
        sck_out = pol;
        sdi_out = b[7];
    endtask
    // master role: 800 ns bit period, clock still outside frames
    task automatic sel(input logic v);
        sck_out = pol;
        ss_n    = v;
        #413;
    endtask
    task automatic bits(input int cnt);
        repeat (cnt) begin
            sdi_out = tx[7];
            #400 sck_out = ~pol;
            rx = {rx[6:0], sdo_in};
            #400 sck_out = pol;
            tx = {tx[6:0], ~tx[0]};
        end
        sdi_out = ~sdi_out;
    endtask
endmodule // spi_far_end
`default_nettype wire

// ===== tb/spi_master_slave_port_tb_top.sv
/*
 * self-checking bench for the serial port: registers, master rates and data, slave.
 * assumes the far-end model in spi_far_end and a 10 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module spi_master_slave_port_tb_top;
    import sync_serial_pkg::*;
    logic        clk, rst, cyc, stb, we, sleep, lead, pol, ss_n, sdi, fsck, be_lo;
    logic        ack, sck_o, sck_oe, sdo, sdo_oe, done, wake;
    logic        tick = 1'b0;
    logic [4:0]  adr;
    logic [3:0]  byte_en;
    logic [31:0] dat, rdat, seed;
    logic [7:0]  b, t, expq[$];
    string       nameq[$];
    int          miscompares, check_count, i, k;
    int          tc = 0;
    wire logic   sck_w;
    logic [4:0]  ofs [7] = '{OFS_STATUS, OFS_CONTROL1, OFS_CONTROL3, OFS_DATA,
                             OFS_BAUD, OFS_FLAGS, 5'h1c};
    logic [3:0]  modes [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER, MODE_RELOAD};
    int          halves [5] = '{2, 8, 32, 5, 12};
    assign sck_w = sck_oe ? sck_o : fsck;
    sync_serial_port sync_serial_port_inst (.MCLK(clk), .SYS_RST(rst), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(byte_en), .DAT_I(dat), .DAT_O(rdat),
        .ACK_O(ack), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .SDI(sdi),
        .SDO_O(sdo), .SDO_OE(sdo_oe), .SS_N(ss_n), .TIMER_TWO_TICK(tick),
        .SLEEP(sleep), .XFER_DONE(done), .WAKE_REQ(wake));
    spi_far_end spi_far_end_inst (.lead(lead), .pol(pol), .sck_in(sck_w),
        .sdo_in(sdo_oe ? sdo : ~sdo), .sck_out(fsck), .sdi_out(sdi), .ss_n(ss_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        tc   <= (tc == 4) ? 0 : tc + 1;
        tick <= (tc == 4);
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle; a read notes its expected byte for the monitor
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                      input string nm, input logic [7:0] e);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        byte_en <= {seed[3:1], be_lo};
        if (!w) begin
            expq.push_back(e);
            nameq.push_back(nm);
        end
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
            check(nameq.pop_front(), rdat, {24'h0, expq.pop_front()});
        end
    end
    task automatic edge_gap(output int n);
        logic s;
        s = sck_o;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sck_o === s && n < 400);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #3000000;
        miscompares++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        {cyc, stb, we, sleep, lead, pol} = 6'h00;
        {byte_en, be_lo} = 5'h01;
        adr = 5'h00;
        dat = 32'h0;
        seed = 32'h1856;
        miscompares = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[j]) wb(1'b0, ofs[j], 8'h00, "reset value", 8'h00);
        wb(1'b1, OFS_STATUS, 8'hff, "", 8'h00);
        wb(1'b0, OFS_STATUS, 8'h00, "status access", 8'hc0);
        wb(1'b1, OFS_BAUD, 8'h05, "", 8'h00);
        be_lo = 1'b0;
        wb(1'b1, OFS_BAUD, 8'h77, "", 8'h00);
        be_lo = 1'b1;
        wb(1'b0, OFS_BAUD, 8'h00, "reload value", 8'h05);
        wb(1'b1, 5'h1c, 8'hff, "", 8'h00);
        wb(1'b0, 5'h1c, 8'h00, "unmapped", 8'h00);
        wb(1'b1, OFS_STATUS, 8'h40, "", 8'h00);
        $display("test registers done");
        for (i = 0; i < 5; i++) begin
            pol = i[0];
            wb(1'b1, OFS_CONTROL1, 8'h00, "", 8'h00);
            wb(1'b1, OFS_STATUS, {~i[0], 7'h40}, "", 8'h00);
            wb(1'b1, OFS_CONTROL1, {2'b00, 1'b1, pol, modes[i]}, "", 8'h00);
            b = rnd();
            t = rnd();
            spi_far_end_inst.load(t);
            @(negedge clk);
            check("sck idle", sck_o, pol);
            check("sck drive", sck_oe, 1'b1);
            wb(1'b1, OFS_DATA, b, "", 8'h00);
            edge_gap(k);
            check("start", k <= halves[i] + 3, 1'b1);
            edge_gap(k);
            check("half bit", k, halves[i]);
            wait_done();
            check("done", done, 1'b1);
            check("far rx", spi_far_end_inst.rx, b);
            wb(1'b0, OFS_STATUS, 8'h00, "full", {~i[0], 7'h41});
            wb(1'b0, OFS_DATA, 8'h00, "rx byte", t);
            wb(1'b0, OFS_STATUS, 8'h00, "full clear", {~i[0], 7'h40});
            wb(1'b1, OFS_FLAGS, 8'h01, "", 8'h00);
            wb(1'b0, OFS_FLAGS, 8'h00, "done clear", 8'h00);
        end
        $display("test master rates done");
        wb(1'b1, OFS_STATUS, 8'h40, "", 8'h00);
        pol = 1'b0;
        wb(1'b1, OFS_CONTROL1, 8'h00, "", 8'h00);
        wb(1'b1, OFS_CONTROL1, 8'h21, "", 8'h00);
        b = rnd();
        t = rnd();
        spi_far_end_inst.load(t);
        wb(1'b1, OFS_DATA, b, "", 8'h00);
        wb(1'b1, OFS_DATA, ~b, "", 8'h00);
        wait_done();
        check("far rx", spi_far_end_inst.rx, b);
        wb(1'b0, OFS_CONTROL1, 8'h00, "collision", 8'ha1);
        wb(1'b1, OFS_FLAGS, 8'h01, "", 8'h00);
        wb(1'b0, OFS_DATA, 8'h00, "rx byte", t);
        wb(1'b1, OFS_DATA, b, "", 8'h00);
        repeat (300) @(posedge clk);
        check("blocked", done, 1'b0);
        wb(1'b1, OFS_CONTROL1, 8'h21, "", 8'h00);
        spi_far_end_inst.load(t);
        wb(1'b1, OFS_DATA, ~b, "", 8'h00);
        wait_done();
        check("far rx", spi_far_end_inst.rx, 8'(~b));
        wb(1'b1, OFS_FLAGS, 8'h01, "", 8'h00);
        wb(1'b0, OFS_DATA, 8'h00, "rx byte", t);
        wb(1'b1, OFS_CONTROL1, 8'h00, "", 8'h00);
        wb(1'b1, OFS_DATA, 8'h55, "", 8'h00);
        wb(1'b0, OFS_CONTROL1, 8'h00, "disabled", 8'h80);
        $display("test collision done");
        lead = 1'b1;
        wb(1'b1, OFS_FLAGS, 8'h02, "", 8'h00);
        wb(1'b1, OFS_CONTROL1, 8'h24, "", 8'h00);
        @(negedge clk);
        check("sck drive", sck_oe, 1'b0);
        b = rnd();
        t = rnd();
        spi_far_end_inst.load(t);
        wb(1'b1, OFS_DATA, b, "", 8'h00);
        sleep <= 1'b1;
        spi_far_end_inst.sel(1'b0);
        check("sdo drive", sdo_oe, 1'b1);
        spi_far_end_inst.bits(8);
        wait_done();
        check("done", done, 1'b1);
        check("far rx", spi_far_end_inst.rx, b);
        repeat (2) @(posedge clk);
        check("wake", wake, 1'b1);
        spi_far_end_inst.sel(1'b1);
        check("sdo release", sdo_oe, 1'b0);
        sleep <= 1'b0;
        wb(1'b1, OFS_FLAGS, 8'h03, "", 8'h00);
        wb(1'b0, OFS_DATA, 8'h00, "rx byte", t);
        spi_far_end_inst.load(rnd());
        wb(1'b1, OFS_DATA, rnd(), "", 8'h00);
        spi_far_end_inst.sel(1'b0);
        spi_far_end_inst.bits(3);
        spi_far_end_inst.sel(1'b1);
        check("sdo release", sdo_oe, 1'b0);
        b = rnd();
        t = rnd();
        spi_far_end_inst.load(t);
        wb(1'b1, OFS_DATA, b, "", 8'h00);
        spi_far_end_inst.sel(1'b0);
        spi_far_end_inst.bits(8);
        wait_done();
        check("far rx", spi_far_end_inst.rx, b);
        spi_far_end_inst.sel(1'b1);
        wb(1'b1, OFS_DATA, 8'h3c, "", 8'h00);
        wb(1'b0, OFS_CONTROL1, 8'h00, "unread refuse", 8'ha4);
        wb(1'b1, OFS_CONTROL1, 8'h24, "", 8'h00);
        wb(1'b1, OFS_CONTROL3, 8'h10, "", 8'h00);
        wb(1'b1, OFS_DATA, 8'h3c, "", 8'h00);
        wb(1'b0, OFS_CONTROL1, 8'h00, "overwrite", 8'h24);
        wb(1'b0, OFS_DATA, 8'h00, "rx byte", 8'h3c);
        wb(1'b1, OFS_CONTROL1, 8'h00, "", 8'h00);
        wb(1'b1, OFS_CONTROL1, 8'h25, "", 8'h00);
        wb(1'b1, OFS_FLAGS, 8'h01, "", 8'h00);
        b = rnd();
        spi_far_end_inst.load(~b);
        wb(1'b1, OFS_DATA, b, "", 8'h00);
        spi_far_end_inst.bits(8);
        wait_done();
        check("done", done, 1'b1);
        check("far rx", spi_far_end_inst.rx, b);
        wb(1'b0, OFS_DATA, 8'h00, "rx byte", ~b);
        $display("test slave done");
        finish_test();
    end
endmodule // spi_master_slave_port_tb_top
`default_nettype wire
